// File: bridge_memory_window_decode.sv
// Purpose: Memory window registers and decode for a virtual bridge port
// Assumes: Requests and config accesses come from logic on clk
// Notes: One cycle from request to routing result and to read data
`timescale 1ns/1ns
module bridge_memory_window_decode
    import bridge_window_pkg::*;
#(
    parameter bit PREFETCH_64 = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire cfg_req_s cfg_req,
    output logic [31:0] cfg_rdata,
    output logic cfg_rvalid,
    input wire logic [11:0] nonprefetch_base,
    input wire mem_req_s mem_req,
    output route_s route
);

    // Width code fixed by the build option
    localparam logic [3:0] WIDTH_CODE =
        PREFETCH_64 ? WIDTH_CODE_64 : WIDTH_CODE_32;

    logic [11:0] nonprefetch_limit_reg, nonprefetch_limit_next;
    logic [11:0] prefetch_base_reg, prefetch_base_next;
    logic [11:0] prefetch_limit_reg, prefetch_limit_next;
    logic [31:0] prefetch_base_upper_reg, prefetch_base_upper_next;
    logic [31:0] prefetch_limit_upper_reg, prefetch_limit_upper_next;
    logic [31:0] cfg_rdata_reg, cfg_rdata_next;
    logic cfg_rvalid_reg, cfg_rvalid_next;
    route_s route_reg, route_next;

    logic [15:0] nonprefetch_limit;
    logic [15:0] prefetch_base;
    logic [15:0] prefetch_limit;
    logic [31:0] upper_base_view, upper_limit_view;
    logic [5:0] dw;
    logic [63:0] pf_lo, pf_hi, np_lo, np_hi;

    // Byte-lane merge of a 12-bit field held in register bits 15:4
    function automatic logic [11:0] merge_field(
        input logic [11:0] old,
        input logic [15:0] data,
        input logic [1:0] be
    );
        logic [11:0] res;
        res = old;
        if (be[1]) begin
            res[11:4] = data[15:8];
        end
        if (be[0]) begin
            res[3:0] = data[7:4];
        end
        return res;
    endfunction : merge_field

    // Byte-lane merge of a full 32-bit register
    function automatic logic [31:0] merge_word(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0] be
    );
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_word

    // Register views; low nibbles are constants, never stored
    assign nonprefetch_limit = {nonprefetch_limit_reg, 4'h0};
    assign prefetch_base = {prefetch_base_reg, WIDTH_CODE};
    assign prefetch_limit = {prefetch_limit_reg, WIDTH_CODE};
    // Upper words vanish when only 32-bit addressing is offered
    assign upper_base_view =
        PREFETCH_64 ? prefetch_base_upper_reg : 32'h0000_0000;
    assign upper_limit_view =
        PREFETCH_64 ? prefetch_limit_upper_reg : 32'h0000_0000;
    assign dw = cfg_req.addr[7:2];

    // Config writes; each 16-bit register sits in one half of its dword
    always_comb begin
        nonprefetch_limit_next = nonprefetch_limit_reg;
        prefetch_base_next = prefetch_base_reg;
        prefetch_limit_next = prefetch_limit_reg;
        prefetch_base_upper_next = prefetch_base_upper_reg;
        prefetch_limit_upper_next = prefetch_limit_upper_reg;
        if (cfg_req.wr) begin
            if (dw == OFS_NONPREFETCH_LIMIT[7:2]) begin
                nonprefetch_limit_next = merge_field(nonprefetch_limit_reg,
                    cfg_req.wdata[31:16], cfg_req.be[3:2]);
            end
            if (dw == OFS_PREFETCH_BASE[7:2]) begin
                prefetch_base_next = merge_field(prefetch_base_reg,
                    cfg_req.wdata[15:0], cfg_req.be[1:0]);
            end
            if (dw == OFS_PREFETCH_LIMIT[7:2]) begin
                prefetch_limit_next = merge_field(prefetch_limit_reg,
                    cfg_req.wdata[31:16], cfg_req.be[3:2]);
            end
            // Writes to the upper words are dropped in 32-bit builds
            if (PREFETCH_64 && dw == OFS_PREFETCH_BASE_UPPER[7:2]) begin
                prefetch_base_upper_next = merge_word(
                    prefetch_base_upper_reg, cfg_req.wdata,
                    cfg_req.be);
            end
            if (PREFETCH_64 && dw == OFS_PREFETCH_LIMIT_UPPER[7:2]) begin
                prefetch_limit_upper_next = merge_word(
                    prefetch_limit_upper_reg, cfg_req.wdata,
                    cfg_req.be);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nonprefetch_limit_reg <= RST_WINDOW_FIELD;
            prefetch_base_reg <= RST_WINDOW_FIELD;
            prefetch_limit_reg <= RST_WINDOW_FIELD;
            prefetch_base_upper_reg <= RST_UPPER;
            prefetch_limit_upper_reg <= RST_UPPER;
        end else begin
            nonprefetch_limit_reg <= nonprefetch_limit_next;
            prefetch_base_reg <= prefetch_base_next;
            prefetch_limit_reg <= prefetch_limit_next;
            prefetch_base_upper_reg <= prefetch_base_upper_next;
            prefetch_limit_upper_reg <= prefetch_limit_upper_next;
        end
    end

    // Read path; the non-prefetch base half of dword 20h reads zero here
    always_comb begin
        cfg_rvalid_next = cfg_req.rd;
        cfg_rdata_next = cfg_rdata_reg;
        if (cfg_req.rd) begin
            case (dw)
                OFS_NONPREFETCH_LIMIT[7:2]:
                    cfg_rdata_next = {nonprefetch_limit, 16'h0000};
                OFS_PREFETCH_BASE[7:2]:
                    cfg_rdata_next = {prefetch_limit, prefetch_base};
                OFS_PREFETCH_BASE_UPPER[7:2]:
                    cfg_rdata_next = upper_base_view;
                OFS_PREFETCH_LIMIT_UPPER[7:2]:
                    cfg_rdata_next = upper_limit_view;
                default:
                    cfg_rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_rdata_reg <= 32'h0000_0000;
            cfg_rvalid_reg <= 1'b0;
        end else begin
            cfg_rdata_reg <= cfg_rdata_next;
            cfg_rvalid_reg <= cfg_rvalid_next;
        end
    end

    // Full 64-bit window bounds; low 20 bits padded per bound type
    assign np_lo = {32'h0000_0000, nonprefetch_base, 20'h00000};
    assign np_hi = {32'h0000_0000, nonprefetch_limit_reg,
        20'hFFFFF};
    assign pf_lo = {upper_base_view, prefetch_base_reg,
        20'h00000};
    assign pf_hi = {upper_limit_view, prefetch_limit_reg,
        20'hFFFFF};

    // Inclusive compares; overlapping windows may both hit, no arbitration
    always_comb begin
        route_next.valid = mem_req.valid;
        route_next.addr = mem_req.addr;
        route_next.np_hit = mem_req.valid &&
            mem_req.addr >= np_lo && mem_req.addr <= np_hi;
        route_next.pf_hit = mem_req.valid &&
            mem_req.addr >= pf_lo &&
            mem_req.addr <= pf_hi;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            route_reg <= '0;
        end else begin
            route_reg <= route_next;
        end
    end

    assign cfg_rdata = cfg_rdata_reg;
    assign cfg_rvalid = cfg_rvalid_reg;
    assign route = route_reg;

    // Checks on reads of the window registers
    a_np_low_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        cfg_req.rd && dw == OFS_NONPREFETCH_LIMIT[7:2]
        |=> cfg_rvalid && cfg_rdata[19:16] == 4'h0)
        else $error("non-prefetch limit low nibble not zero");

    a_width_code_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        cfg_req.rd && dw == OFS_PREFETCH_BASE[7:2]
        |=> cfg_rdata[3:0] == WIDTH_CODE)
        else $error("prefetch base width code wrong");

    a_codes_match: assert property (
        @(posedge clk) disable iff (!rst_n)
        cfg_req.rd && dw == OFS_PREFETCH_BASE[7:2]
        |=> cfg_rdata[3:0] == cfg_rdata[19:16])
        else $error("prefetch width codes differ");

    a_upper_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        !PREFETCH_64 && cfg_req.rd &&
        (dw == OFS_PREFETCH_BASE_UPPER[7:2] ||
         dw == OFS_PREFETCH_LIMIT_UPPER[7:2])
        |=> cfg_rdata == 32'h0000_0000)
        else $error("upper register not zero in 32-bit build");

    // Read data is the view as it stood at the edge that took the read
    a_upper_rdback: assert property (
        @(posedge clk) disable iff (!rst_n)
        cfg_req.rd && dw == OFS_PREFETCH_BASE_UPPER[7:2]
        |=> cfg_rdata == $past(upper_base_view))
        else $error("upper base read back differs");

    // Checks on writes reaching storage
    a_np_limit_wr: assert property (
        @(posedge clk) disable iff (!rst_n)
        cfg_req.wr && dw == OFS_NONPREFETCH_LIMIT[7:2] &&
        cfg_req.be[3:2] == 2'b11
        |=> nonprefetch_limit_reg == $past(cfg_req.wdata[31:20]))
        else $error("non-prefetch limit write lost");

    a_upper_base_wr: assert property (
        @(posedge clk) disable iff (!rst_n)
        PREFETCH_64 && cfg_req.wr && cfg_req.be == 4'hF &&
        dw == OFS_PREFETCH_BASE_UPPER[7:2]
        |=> upper_base_view == $past(cfg_req.wdata))
        else $error("upper base write lost");

    a_upper_limit_wr: assert property (
        @(posedge clk) disable iff (!rst_n)
        PREFETCH_64 && cfg_req.wr && cfg_req.be == 4'hF &&
        dw == OFS_PREFETCH_LIMIT_UPPER[7:2]
        |=> upper_limit_view == $past(cfg_req.wdata))
        else $error("upper limit write lost");

    // Checks on routing results
    a_route_latency: assert property (
        @(posedge clk) disable iff (!rst_n)
        mem_req.valid |=> route.valid && route.addr == $past(mem_req.addr))
        else $error("route result not one cycle after request");

    a_pf_edges: assert property (
        @(posedge clk) disable iff (!rst_n)
        mem_req.valid && !cfg_req.wr &&
        mem_req.addr[63:20] == {upper_limit_view, prefetch_limit_reg} &&
        pf_lo <= pf_hi
        |=> route.pf_hit)
        else $error("top megabyte of prefetch window missed");

    // Base megabyte hits whenever the window is not inverted
    a_pf_base_edge: assert property (
        @(posedge clk) disable iff (!rst_n)
        mem_req.valid &&
        mem_req.addr[63:20] == {upper_base_view, prefetch_base_reg} &&
        pf_lo <= pf_hi
        |=> route.pf_hit)
        else $error("bottom megabyte of prefetch window missed");

    a_pf_below_miss: assert property (
        @(posedge clk) disable iff (!rst_n)
        mem_req.valid &&
        mem_req.addr[63:20] < {upper_base_view, prefetch_base_reg}
        |=> !route.pf_hit)
        else $error("prefetch hit below base");

    a_np_window: assert property (
        @(posedge clk) disable iff (!rst_n)
        mem_req.valid && mem_req.addr[63:32] == 32'h0000_0000 &&
        mem_req.addr[31:20] >= nonprefetch_base &&
        mem_req.addr[31:20] <= nonprefetch_limit_reg
        |=> route.np_hit)
        else $error("non-prefetch window missed");

    a_np_above_miss: assert property (
        @(posedge clk) disable iff (!rst_n)
        mem_req.valid &&
        mem_req.addr[63:20] > {32'h0000_0000, nonprefetch_limit_reg}
        |=> !route.np_hit)
        else $error("non-prefetch hit above limit");

    a_pf_upper_miss: assert property (
        @(posedge clk) disable iff (!rst_n)
        mem_req.valid && mem_req.addr[63:32] > upper_limit_view
        |=> !route.pf_hit)
        else $error("prefetch hit above upper limit");

endmodule : bridge_memory_window_decode

// File: bridge_window_pkg.sv
// Purpose: Shared constants and carriers for the bridge memory window decode
// Assumes: Config offsets are byte addresses inside one function's space
// Notes: Window fields hold address bits 31:20 in register bits 15:4
package bridge_window_pkg;

    // Byte offsets of the window registers in configuration space
    localparam logic [7:0] OFS_NONPREFETCH_LIMIT = 8'h22;
    localparam logic [7:0] OFS_PREFETCH_BASE = 8'h24;
    localparam logic [7:0] OFS_PREFETCH_LIMIT = 8'h26;
    localparam logic [7:0] OFS_PREFETCH_BASE_UPPER = 8'h28;
    localparam logic [7:0] OFS_PREFETCH_LIMIT_UPPER = 8'h2C;

    // Field layout of the 16-bit window registers
    localparam int FIELD_LSB = 4;
    localparam int FIELD_MSB = 15;
    localparam int DECODE_LSB = 20;
    localparam int DECODE_MSB = 31;

    // Width codes in the read-only low nibble
    localparam logic [3:0] WIDTH_CODE_32 = 4'h0;
    localparam logic [3:0] WIDTH_CODE_64 = 4'h1;

    // Reset values of the stored fields
    localparam logic [11:0] RST_WINDOW_FIELD = 12'h000;
    localparam logic [31:0] RST_UPPER = 32'h0000_0000;

    // Configuration access from the host side
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } cfg_req_s;

    // Processor memory request to be routed
    typedef struct packed {
        logic valid;
        logic [63:0] addr;
    } mem_req_s;

    // Routing decision toward the secondary port
    typedef struct packed {
        logic valid;
        logic np_hit;
        logic pf_hit;
        logic [63:0] addr;
    } route_s;

endpackage : bridge_window_pkg

// File: secondary_port_model.sv
// Purpose: Secondary port sink that counts memory requests routed to it
// Assumes: Route results are single-cycle pulses on clk
// Notes: Misses stay on the host side and are not counted here
`timescale 1ns/1ns
module secondary_port_model
    import bridge_window_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire route_s route,
    output logic [15:0] fwd_count
);
    // One count per forwarded pulse; a miss would be a lost transfer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fwd_count <= 16'h0000;
        end else if (route.valid && (route.np_hit || route.pf_hit)) begin
            fwd_count <= fwd_count + 16'h0001;
        end
    end
endmodule : secondary_port_model

// File: bridge_memory_window_decode_test.sv
// Purpose: Self-checking bench for the bridge memory window decode
// Assumes: One-cycle answers on both the config and the route paths
// Notes: A 32-bit build shares every config access with the 64-bit one
`timescale 1ns/1ns
module bridge_memory_window_decode_test
    import bridge_window_pkg::*;
;
    logic clk;
    logic rst_n;
    cfg_req_s cfg_req;
    logic [31:0] cfg_rdata;
    logic [31:0] rdata32;
    logic cfg_rvalid;
    logic rvalid32;
    logic [11:0] nonprefetch_base;
    mem_req_s mem_req;
    route_s route;
    route_s route32;
    logic [15:0] fwd_count;
    int bad_count;
    int samples_checked;

    bridge_memory_window_decode #(.PREFETCH_64(1'b1)) u_dut (
        .clk(clk), .rst_n(rst_n), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid), .nonprefetch_base(nonprefetch_base),
        .mem_req(mem_req), .route(route));
    // Narrow build sees the same traffic, so its reads cost nothing extra
    bridge_memory_window_decode #(.PREFETCH_64(1'b0)) u_dut32 (
        .clk(clk), .rst_n(rst_n), .cfg_req(cfg_req), .cfg_rdata(rdata32),
        .cfg_rvalid(rvalid32), .nonprefetch_base(nonprefetch_base),
        .mem_req(mem_req), .route(route32));
    secondary_port_model u_sink (
        .clk(clk), .rst_n(rst_n), .route(route), .fwd_count(fwd_count));

    // Clock at 4 ns
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input string name, input logic [63:0] seen,
                         input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic cfg_write(input logic [7:0] a, input logic [3:0] b,
                             input logic [31:0] d);
        @(posedge clk);
        cfg_req <= '{wr: 1'h1, rd: 1'h0, addr: a, be: b, wdata: d};
        @(posedge clk);
        cfg_req.wr <= 1'h0;
    endtask : cfg_write

    // Read data is taken in the one cycle that rvalid stands
    task automatic cfg_read(input logic [7:0] a, input logic [31:0] e,
                            input logic [31:0] e32);
        @(posedge clk);
        cfg_req <= '{wr: 1'h0, rd: 1'h1, addr: a, be: 4'h0, wdata: 32'h0};
        @(posedge clk);
        cfg_req.rd <= 1'h0;
        #1;
        check("cfg_rvalid", cfg_rvalid, 1'h1);
        check("cfg_rdata", cfg_rdata, e);
        check("rvalid32", rvalid32, 1'h1);
        check("rdata32", rdata32, e32);
    endtask : cfg_read

    // The narrow build ignores upper words, so its prefetch hit differs
    task automatic mem_check(input logic [63:0] a, input logic np,
                             input logic pf, input logic pf32);
        @(posedge clk);
        mem_req <= '{valid: 1'h1, addr: a};
        @(posedge clk);
        mem_req.valid <= 1'h0;
        #1;
        check("route_valid", route.valid, 1'h1);
        check("route_hits", {route.np_hit, route.pf_hit}, {np, pf});
        check("route_addr", route.addr, a);
        check("route32_pf", route32.pf_hit, pf32);
    endtask : mem_check

    task automatic reset_values;
        cfg_read(8'h20, 32'h0000_0000, 32'h0000_0000);
        cfg_read(8'h24, 32'h0001_0001, 32'h0000_0000);
        cfg_read(8'h28, 32'h0000_0000, 32'h0000_0000);
        cfg_read(8'h2C, 32'h0000_0000, 32'h0000_0000);
    endtask : reset_values

    // All-ones writes expose any writable low nibble
    task automatic register_access;
        cfg_write(8'h20, 4'hF, 32'hFFFF_FFFF);
        cfg_read(8'h20, 32'hFFF0_0000, 32'hFFF0_0000);
        cfg_write(8'h20, 4'h8, 32'hAB00_0000);
        cfg_read(8'h20, 32'hABF0_0000, 32'hABF0_0000);
        cfg_write(8'h24, 4'hF, 32'hFFFF_FFFF);
        cfg_read(8'h24, 32'hFFF1_FFF1, 32'hFFF0_FFF0);
        cfg_write(8'h28, 4'hF, 32'hFFFF_FFFF);
        cfg_write(8'h2C, 4'hF, 32'h1234_5678);
        cfg_read(8'h28, 32'hFFFF_FFFF, 32'h0000_0000);
        cfg_read(8'h2C, 32'h1234_5678, 32'h0000_0000);
        cfg_write(8'h30, 4'hF, 32'hFFFF_FFFF);
        cfg_read(8'h30, 32'h0000_0000, 32'h0000_0000);
    endtask : register_access

    // Disjoint windows: np 100h..1FFh, pf 300h..3FFh
    task automatic decode_32;
        cfg_write(8'h20, 4'hC, 32'h1FF0_0000);
        nonprefetch_base <= 12'h100;
        cfg_write(8'h24, 4'hF, 32'h3FF0_3000);
        cfg_write(8'h28, 4'hF, 32'h0000_0000);
        cfg_write(8'h2C, 4'hF, 32'h0000_0000);
        mem_check(64'h0FFF_FFFF, 1'h0, 1'h0, 1'h0);
        mem_check(64'h1000_0000, 1'h1, 1'h0, 1'h0);
        mem_check(64'h1FFF_FFFF, 1'h1, 1'h0, 1'h0);
        mem_check(64'h2FFF_FFFF, 1'h0, 1'h0, 1'h0);
        mem_check(64'h3000_0000, 1'h0, 1'h1, 1'h1);
        mem_check(64'h3FFF_FFFF, 1'h0, 1'h1, 1'h1);
        mem_check(64'h4000_0000, 1'h0, 1'h0, 1'h0);
    endtask : decode_32

    // Upper words 1 and 2 make the window span a 4 GB boundary
    task automatic decode_64;
        cfg_write(8'h28, 4'hF, 32'h0000_0001);
        cfg_write(8'h2C, 4'hF, 32'h0000_0002);
        mem_check(64'h0000_0000_3000_0000, 1'h0, 1'h0, 1'h1);
        mem_check(64'h0000_0001_2FFF_FFFF, 1'h0, 1'h0, 1'h0);
        mem_check(64'h0000_0001_3000_0000, 1'h0, 1'h1, 1'h0);
        mem_check(64'h0000_0001_1000_0000, 1'h0, 1'h0, 1'h0);
        mem_check(64'h0000_0002_0000_0000, 1'h0, 1'h1, 1'h0);
        mem_check(64'h0000_0002_3FFF_FFFF, 1'h0, 1'h1, 1'h0);
        mem_check(64'h0000_0002_4000_0000, 1'h0, 1'h0, 1'h0);
        #1;
        check("fwd_count", fwd_count, 16'h0007);
    endtask : decode_64

    // Main sequence, reset held for 16 cycles
    initial begin
        rst_n = 1'h0;
        cfg_req = '0;
        mem_req = '0;
        nonprefetch_base = 12'h000;
        bad_count = 0;
        samples_checked = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        reset_values();
        register_access();
        decode_32();
        decode_64();
        report_and_stop();
    end

    // Cuts a hang short and counts it as a mismatch
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end
endmodule : bridge_memory_window_decode_test
